// ==== lpt_pkg.sv ====
package lpt_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_RATE_TABLE = 8'h5f;
  localparam logic [7:0] OP_POWER_CTRL = 8'h25;
  localparam logic [7:0] OP_RATE_LEVEL = 8'h2b;
  localparam logic [7:0] OP_BIAS = 8'ha2;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_DISCHARGE = 8'hea;
  localparam logic [7:0] OP_STANDBY = 8'ha8;
  localparam logic [7:0] OP_STANDBY_MASK = 8'hfe;
  localparam logic [7:0] OP_SLOPE = 8'h4e;
  localparam logic [7:0] OP_SLOPE_SIGN = 8'h39;
  localparam logic [7:0] OP_STATUS = 8'h8e;
  localparam logic [7:0] OP_OSC = 8'haa;
  localparam logic [7:0] OP_OSC_MASK = 8'hfe;
  localparam logic [7:0] OP_DISPLAY = 8'hae;
  localparam logic [7:0] OP_DISPLAY_MASK = 8'hfe;
  localparam logic [7:0] OP_SCAN = 8'hc4;
  localparam logic [7:0] OP_TEMP_DETECT = 8'h68;
  localparam logic [7:0] OP_TEMP_DETECT_MASK = 8'hfe;
  localparam logic [7:0] OP_DRIVE_METHOD = 8'he7;
  // ==========================================================
  // Field layout and limits
  localparam int POWER_BITS = 7;
  localparam int BIAS_BITS = 4;
  localparam int DISCH_BITS = 4;
  localparam int CONTRAST_BITS = 10;
  localparam int BANDS = 16;
  localparam int INVERSION_RESET_BY_FRAME_FLAG_POS = 4;
  localparam logic [3:0] BIAS_MAX = 4'ha;
  localparam logic [9:0] CONTRAST_MAX = 10'h23f;
  localparam logic [3:0] POS_SLOPE_MAX = 4'h3;
  localparam logic [3:0] MAX_PARAMS = 4'h8;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [9:0] CONTRAST_RST = 10'h000;
  localparam logic [3:0] BIAS_RST = 4'h0;
endpackage

// ==== lpt_if.sv ====
`timescale 1ns/1ps
interface lpt_if;
  logic cmd_param_select;
  logic rd_not_wr;
  logic strobe;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport host (output cmd_param_select, output rd_not_wr, output strobe, output wdata,
    input rdata, input rvalid);
  modport dev (input cmd_param_select, input rd_not_wr, input strobe, input wdata,
    output rdata, output rvalid);
endinterface // lpt_if

// ==== lpt_device.sv ====
// Behaviour
// - Don't-care parameter bits are ignored
// - Rate table: two bytes, four band nibbles
// - Single-rate table from code to fps
// - Doubled table from code to fps
// - Rate level bit 0 picks doubling
// - Power byte bits 6..0 enable blocks
// - Host starts oscillator before power on
// - Host runs external clock before power
// - Bias low nibble, 1/6 to 1/16
// - Contrast: low byte, then upper two
// - Discharge byte bits 3..0 per supply
// - Host discharges only supplies turned off
// - Opcode bit 0 enters or leaves standby
// - Slope command: eight bytes, sixteen nibbles
// - Positive slopes limited to three
// - Slope n gives n times 10 mV/degree
// - Sign command: two bytes, bands 7..0 first
// - Status read returns two flag bytes
// - Set bit means on, except inversion reset
`timescale 1ns/1ps
module lpt_device (
  input wire logic i_mclk,
  input wire logic i_rst,
  lpt_if.dev bus,
  input wire logic [3:0] i_band_sel,
  output logic [15:0] o_rate_codes,
  output logic o_rate_doubler,
  output logic [8:0] o_frame_rate,
  output logic [6:0] o_power_on,
  output logic [3:0] o_bias_ratio_code,
  output logic [4:0] o_bias_denominator,
  output logic [9:0] o_contrast_code,
  output logic [3:0] o_discharge,
  output logic o_standby,
  output logic o_oscillator_on,
  output logic [63:0] o_slope_codes,
  output logic [15:0] o_slope_signs,
  output logic signed [8:0] o_band_coeff_10mv
);
  import lpt_pkg::*;

  // ==========================================================
  // Lookup functions
  // single-rate table
  function automatic logic [8:0] rate_x1(input logic [3:0] c);
    logic [8:0] r;
    r = 9'h000;
    case (c)
      4'h0: r = 9'd143; 4'h1: r = 9'd117; 4'h2: r = 9'd98; 4'h3: r = 9'd80;
      4'h4: r = 9'd72; 4'h5: r = 9'd62; 4'h6: r = 9'd58; 4'h7: r = 9'd54;
      4'h8: r = 9'd48; 4'h9: r = 9'd44; 4'ha: r = 9'd40; 4'hb: r = 9'd38;
      4'hc: r = 9'd36; 4'hd: r = 9'd34; 4'he: r = 9'd12; default: r = 9'd5;
    endcase
    return r;
  endfunction

  function automatic logic [8:0] rate_x2(input logic [3:0] c);
    logic [8:0] r;
    r = 9'h000;
    case (c)
      4'h0: r = 9'd286; 4'h1: r = 9'd234; 4'h2: r = 9'd198; 4'h3: r = 9'd161;
      4'h4: r = 9'd143; 4'h5: r = 9'd123; 4'h6: r = 9'd117; 4'h7: r = 9'd107;
      4'h8: r = 9'd95; 4'h9: r = 9'd87; 4'ha: r = 9'd81; 4'hb: r = 9'd78;
      4'hc: r = 9'd72; 4'hd: r = 9'd67; 4'he: r = 9'd24; default: r = 9'd10;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Command tracking
  logic [7:0] op_reg;
  logic [3:0] idx_reg;
  logic wr_cmd, wr_par, rd_par;
  assign wr_cmd = bus.strobe && !bus.cmd_param_select && !bus.rd_not_wr;
  assign wr_par = bus.strobe && bus.cmd_param_select && !bus.rd_not_wr;
  assign rd_par = bus.strobe && bus.cmd_param_select && bus.rd_not_wr;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      op_reg <= 8'h00;
      idx_reg <= 4'h0;
    end else if (wr_cmd) begin
      op_reg <= bus.wdata;
      idx_reg <= 4'h0;
    end else if ((wr_par || rd_par) && idx_reg < MAX_PARAMS) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  // ==========================================================
  // Settings
  logic [15:0] rate_reg;
  logic dbl_reg;
  logic [6:0] power_reg;
  logic [3:0] bias_reg;
  logic [9:0] contrast_reg;
  logic [7:0] contrast_lo_reg;
  logic [3:0] disch_reg;
  logic standby_reg, osc_reg, disp_reg, scan_il_reg, scan_rev_reg, temp_det_reg, inversion_reset_by_frame_flag_reg;
  logic [63:0] slope_reg;
  logic [15:0] sign_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) rate_reg <= RATE_RST;
    else if (wr_par && op_reg == OP_RATE_TABLE && idx_reg == 4'h0) rate_reg[7:0] <= bus.wdata;
    else if (wr_par && op_reg == OP_RATE_TABLE && idx_reg == 4'h1) rate_reg[15:8] <= bus.wdata;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) dbl_reg <= 1'b0;
    else if (wr_par && op_reg == OP_RATE_LEVEL && idx_reg == 4'h0) dbl_reg <= bus.wdata[0];
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) power_reg <= '0;
    else if (wr_par && op_reg == OP_POWER_CTRL && idx_reg == 4'h0) power_reg <= bus.wdata[POWER_BITS-1:0];
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) bias_reg <= BIAS_RST;
    else if (wr_par && op_reg == OP_BIAS && idx_reg == 4'h0 && bus.wdata[3:0] <= BIAS_MAX)
      bias_reg <= bus.wdata[BIAS_BITS-1:0];
  end

  // contrast low then high
  // Code applied whole on second byte so no half-updated value shows
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      contrast_lo_reg <= 8'h00;
      contrast_reg <= CONTRAST_RST;
    end else if (wr_par && op_reg == OP_CONTRAST && idx_reg == 4'h0) begin
      contrast_lo_reg <= bus.wdata;
    end else if (wr_par && op_reg == OP_CONTRAST && idx_reg == 4'h1) begin
      contrast_reg <= ({bus.wdata[1:0], contrast_lo_reg} > CONTRAST_MAX) ? CONTRAST_MAX
        : {bus.wdata[1:0], contrast_lo_reg};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) disch_reg <= '0;
    else if (wr_par && op_reg == OP_DISCHARGE && idx_reg == 4'h0) disch_reg <= bus.wdata[DISCH_BITS-1:0];
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) standby_reg <= 1'b0;
    else if (wr_cmd && (bus.wdata & OP_STANDBY_MASK) == OP_STANDBY) standby_reg <= bus.wdata[0];
  end

  // Single-opcode flags that feed the status bytes
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      osc_reg <= 1'b0;
      disp_reg <= 1'b0;
      temp_det_reg <= 1'b0;
    end else if (wr_cmd) begin
      if ((bus.wdata & OP_OSC_MASK) == OP_OSC) osc_reg <= bus.wdata[0];
      if ((bus.wdata & OP_DISPLAY_MASK) == OP_DISPLAY) disp_reg <= bus.wdata[0];
      if ((bus.wdata & OP_TEMP_DETECT_MASK) == OP_TEMP_DETECT) temp_det_reg <= bus.wdata[0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      scan_il_reg <= 1'b0;
      scan_rev_reg <= 1'b0;
      inversion_reset_by_frame_flag_reg <= 1'b0;
    end else if (wr_par && idx_reg == 4'h0) begin
      if (op_reg == OP_SCAN) begin
        scan_il_reg <= bus.wdata[1];
        scan_rev_reg <= bus.wdata[0];
      end
      if (op_reg == OP_DRIVE_METHOD) inversion_reset_by_frame_flag_reg <= bus.wdata[INVERSION_RESET_BY_FRAME_FLAG_POS];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) slope_reg <= '0;
    else if (wr_par && op_reg == OP_SLOPE && idx_reg < MAX_PARAMS)
      slope_reg[idx_reg[2:0]*8 +: 8] <= bus.wdata;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) sign_reg <= '0;
    else if (wr_par && op_reg == OP_SLOPE_SIGN && idx_reg == 4'h0) sign_reg[7:0] <= bus.wdata;
    else if (wr_par && op_reg == OP_SLOPE_SIGN && idx_reg == 4'h1) sign_reg[15:8] <= bus.wdata;
  end

  // ==========================================================
  // Status read
  // two status bytes
  // inversion_reset_by_frame_flag bit set means reset off
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus.rdata <= 8'h00;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= rd_par && op_reg == OP_STATUS && idx_reg < 4'h2;
      if (rd_par && op_reg == OP_STATUS && idx_reg == 4'h0)
        bus.rdata <= {disp_reg, osc_reg, power_reg[5:0]};
      else if (rd_par && op_reg == OP_STATUS && idx_reg == 4'h1)
        bus.rdata <= {|disch_reg, scan_il_reg, scan_rev_reg, standby_reg, temp_det_reg, inversion_reset_by_frame_flag_reg, 1'b0, 1'b0};
      else
        bus.rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Outputs
  logic [3:0] band_code;
  logic [3:0] band_slope;
  logic [3:0] slope_eff;
  assign band_code = rate_reg[i_band_sel[1:0]*4 +: 4];
  assign band_slope = slope_reg[i_band_sel*4 +: 4];
  assign slope_eff = (sign_reg[i_band_sel] && band_slope > POS_SLOPE_MAX) ? POS_SLOPE_MAX : band_slope;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_frame_rate <= 9'h000;
      o_band_coeff_10mv <= 9'sh000;
      o_bias_denominator <= 5'h06;
    end else begin
      o_frame_rate <= dbl_reg ? rate_x2(band_code) : rate_x1(band_code);
      // signed coefficient in 10 mV units
      o_band_coeff_10mv <= sign_reg[i_band_sel] ? $signed({5'h00, slope_eff}) : -$signed({5'h00, slope_eff});
      o_bias_denominator <= 5'h06 + {1'b0, bias_reg};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rate_codes <= '0;
      o_rate_doubler <= 1'b0;
      o_power_on <= '0;
      o_bias_ratio_code <= '0;
      o_contrast_code <= '0;
      o_discharge <= '0;
      o_standby <= 1'b0;
      o_oscillator_on <= 1'b0;
      o_slope_codes <= '0;
      o_slope_signs <= '0;
    end else begin
      o_rate_codes <= rate_reg;
      o_rate_doubler <= dbl_reg;
      // Standby shuts analog blocks without discharging them
      o_power_on <= standby_reg ? 7'h00 : power_reg;
      o_bias_ratio_code <= bias_reg;
      o_contrast_code <= contrast_reg;
      o_discharge <= disch_reg;
      o_standby <= standby_reg;
      o_oscillator_on <= osc_reg;
      o_slope_codes <= slope_reg;
      o_slope_signs <= sign_reg;
    end
  end
endmodule // lpt_device

// ==== lpt_host.sv ====
`timescale 1ns/1ps
module lpt_host (
  input wire logic i_mclk,
  input wire logic i_rst,
  lpt_if.host bus,
  input wire logic i_req,
  input wire logic i_req_param,
  input wire logic i_req_read,
  input wire logic [7:0] i_req_data,
  output logic o_busy,
  output logic o_rvalid,
  output logic [7:0] o_rdata,
  output logic o_order_error
);
  import lpt_pkg::*;

  // ==========================================================
  // Byte drive, one strobe cycle per request
  // select follows request kind
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus.strobe <= 1'b0;
      bus.cmd_param_select <= 1'b0;
      bus.rd_not_wr <= 1'b0;
      bus.wdata <= 8'h00;
    end else begin
      bus.strobe <= i_req;
      if (i_req) begin
        bus.cmd_param_select <= i_req_param;
        bus.rd_not_wr <= i_req_read && i_req_param;
        bus.wdata <= i_req_data;
      end
    end
  end

  // ==========================================================
  // Power ordering watch
  logic osc_seen_reg;
  logic [6:0] power_mirror_reg;
  logic [7:0] last_op_reg;
  logic first_param_reg;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      osc_seen_reg <= 1'b0;
      last_op_reg <= 8'h00;
      first_param_reg <= 1'b0;
      power_mirror_reg <= '0;
      o_order_error <= 1'b0;
    end else if (i_req && !i_req_param) begin
      last_op_reg <= i_req_data;
      first_param_reg <= 1'b1;
      if ((i_req_data & OP_OSC_MASK) == OP_OSC) osc_seen_reg <= i_req_data[0];
    end else if (i_req && !i_req_read) begin
      first_param_reg <= 1'b0;
      if (first_param_reg && last_op_reg == OP_POWER_CTRL) begin
        power_mirror_reg <= i_req_data[6:0];
        if (|i_req_data[6:0] && !osc_seen_reg) o_order_error <= 1'b1;
      end
      if (first_param_reg && last_op_reg == OP_DISCHARGE && |i_req_data[3:0] && |power_mirror_reg)
        o_order_error <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_busy <= i_req;
      o_rvalid <= bus.rvalid;
      if (bus.rvalid) o_rdata <= bus.rdata;
    end
  end
endmodule // lpt_host

// ==== lpt_chk.sv ====
`timescale 1ns/1ps
module lpt_chk (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic cmd_param_select,
  input wire logic rd_not_wr,
  input wire logic strobe,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [6:0] o_power_on,
  input wire logic o_standby,
  input wire logic [3:0] o_bias_ratio_code,
  input wire logic o_rate_doubler,
  input wire logic [9:0] o_contrast_code
);
  import lpt_pkg::*;
  // ==========================================================
  // Command tracking
  logic [7:0] op_reg;
  logic [3:0] idx_reg;
  logic [7:0] lo_reg;
  wire wr_c = strobe && !cmd_param_select && !rd_not_wr;
  wire wr_p = strobe && cmd_param_select && !rd_not_wr;
  wire rd_p = strobe && cmd_param_select && rd_not_wr;
  wire [9:0] ev = {wdata[1:0], lo_reg};
  wire [9:0] ev_clip = (ev > CONTRAST_MAX) ? CONTRAST_MAX : ev;
  always_ff @(posedge i_mclk) begin
    if (i_rst) op_reg <= 8'h00;
    else if (wr_c) op_reg <= wdata;
  end
  // Saturates so a long burst cannot wrap back to index 0
  always_ff @(posedge i_mclk) begin
    if (i_rst || wr_c) idx_reg <= 4'h0;
    else if (strobe && cmd_param_select && idx_reg != MAX_PARAMS) idx_reg <= idx_reg + 4'h1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) lo_reg <= 8'h00;
    else if (wr_p && op_reg == OP_CONTRAST && idx_reg == 4'h0) lo_reg <= wdata;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Properties
  property p_rvalid_cause;
    rvalid |-> $past(rd_p && op_reg == OP_STATUS && idx_reg < 4'h2);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("rvalid without status read");
  property p_status_answer;
    rd_p && op_reg == OP_STATUS && idx_reg < 4'h2 |=> rvalid;
  endproperty
  a_status_answer: assert property (p_status_answer) else $error("status byte missing");
  property p_power;
    wr_p && op_reg == OP_POWER_CTRL && idx_reg == 4'h0 && !o_standby |=> ##1 o_power_on == $past(wdata[6:0], 2);
  endproperty
  a_power: assert property (p_power) else $error("power bits wrong");
  property p_bias;
    wr_p && op_reg == OP_BIAS && idx_reg == 4'h0 && wdata[3:0] <= BIAS_MAX |=> ##1
      o_bias_ratio_code == $past(wdata[3:0], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias code wrong");
  property p_bias_refuse;
    wr_p && op_reg == OP_BIAS && idx_reg == 4'h0 && wdata[3:0] > BIAS_MAX |=> ##1
      o_bias_ratio_code == $past(o_bias_ratio_code);
  endproperty
  a_bias_refuse: assert property (p_bias_refuse) else $error("bad bias code taken");
  property p_doubler;
    wr_p && op_reg == OP_RATE_LEVEL && idx_reg == 4'h0 |=> ##1 o_rate_doubler == $past(wdata[0], 2);
  endproperty
  a_doubler: assert property (p_doubler) else $error("doubler wrong");
  property p_contrast;
    wr_p && op_reg == OP_CONTRAST && idx_reg == 4'h1 |=> ##1 o_contrast_code == $past(ev_clip, 2);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast wrong");
  property p_standby;
    wr_c && (wdata & OP_STANDBY_MASK) == OP_STANDBY |=> ##1 o_standby == $past(wdata[0], 2);
  endproperty
  a_standby: assert property (p_standby) else $error("standby wrong");
  property p_standby_off;
    o_standby |-> o_power_on == 7'h00;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("power on in standby");
endmodule // lpt_chk

// ==== lcd_power_temp_cmd_decoder_test.sv ====
`timescale 1ns/1ps
module lcd_power_temp_cmd_decoder_test;
  import lpt_pkg::*;
  typedef struct {logic [7:0] op; logic [7:0] p0; logic [7:0] p1; int n; int sel; logic [15:0] exp;} lpt_row_t;
  logic i_mclk, i_rst, i_req, i_req_param, i_req_read, o_busy, o_rvalid, o_order_error;
  logic [7:0] i_req_data, o_rdata;
  logic [3:0] i_band_sel, o_bias_ratio_code, o_discharge;
  logic [15:0] o_rate_codes, o_slope_signs;
  logic o_rate_doubler, o_standby, o_oscillator_on;
  logic [8:0] o_frame_rate;
  logic [6:0] o_power_on;
  logic [4:0] o_bias_denominator;
  logic [9:0] o_contrast_code;
  logic [63:0] o_slope_codes;
  logic signed [8:0] o_band_coeff_10mv;
  int fails = 0;
  int checks = 0;
  localparam int FR1 [16] = '{143, 117, 98, 80, 72, 62, 58, 54, 48, 44, 40, 38, 36, 34, 12, 5};
  localparam int FR2 [16] = '{286, 234, 198, 161, 143, 123, 117, 107, 95, 87, 81, 78, 72, 67, 24, 10};
  lpt_row_t rows [14] = '{'{8'hab, 0, 0, 0, 0, 1}, '{8'h25, 8'hff, 0, 1, 1, 16'h7f},
    '{8'h2b, 8'hfe, 0, 1, 2, 0}, '{8'h2b, 8'h01, 0, 1, 2, 1}, '{8'ha2, 8'hfa, 0, 1, 3, 16'ha},
    '{8'ha2, 8'h0b, 0, 1, 3, 16'ha}, '{8'ha2, 8'hf3, 0, 1, 4, 9}, '{8'h81, 8'h3f, 8'hfe, 2, 5, 16'h23f},
    '{8'h81, 8'hff, 8'h03, 2, 5, 16'h23f}, '{8'h81, 8'h55, 8'hfd, 2, 5, 16'h155}, '{8'h25, 8'h80, 0, 1, 1, 0},
    '{8'hea, 8'hf5, 0, 1, 6, 5}, '{8'h5f, 8'h21, 8'h43, 2, 7, 16'h4321}, '{8'h39, 8'h81, 8'h7e, 2, 8, 16'h7e81}};
  int bands [4] = '{5, 7, 9, 15};
  int coef [4] = '{-5, 3, 3, -15};
  lpt_if i_lpt_if();
  lpt_host i_lpt_host(.i_mclk(i_mclk), .i_rst(i_rst), .bus(i_lpt_if), .i_req(i_req), .i_req_param(i_req_param),
    .i_req_read(i_req_read), .i_req_data(i_req_data), .o_busy(o_busy), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_order_error(o_order_error));
  lpt_device i_lpt_device(.i_mclk(i_mclk), .i_rst(i_rst), .bus(i_lpt_if), .i_band_sel(i_band_sel),
    .o_rate_codes(o_rate_codes), .o_rate_doubler(o_rate_doubler), .o_frame_rate(o_frame_rate),
    .o_power_on(o_power_on), .o_bias_ratio_code(o_bias_ratio_code), .o_bias_denominator(o_bias_denominator),
    .o_contrast_code(o_contrast_code), .o_discharge(o_discharge), .o_standby(o_standby),
    .o_oscillator_on(o_oscillator_on), .o_slope_codes(o_slope_codes), .o_slope_signs(o_slope_signs),
    .o_band_coeff_10mv(o_band_coeff_10mv));
  lpt_chk i_lpt_chk(.i_mclk(i_mclk), .i_rst(i_rst), .cmd_param_select(i_lpt_if.cmd_param_select),
    .rd_not_wr(i_lpt_if.rd_not_wr), .strobe(i_lpt_if.strobe), .wdata(i_lpt_if.wdata), .rdata(i_lpt_if.rdata),
    .rvalid(i_lpt_if.rvalid), .o_power_on(o_power_on), .o_standby(o_standby),
    .o_bias_ratio_code(o_bias_ratio_code), .o_rate_doubler(o_rate_doubler), .o_contrast_code(o_contrast_code));
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic send(input logic p, input logic r, input logic [7:0] d);
    @(posedge i_mclk);
    i_req <= 1'b1;
    i_req_param <= p;
    i_req_read <= r;
    i_req_data <= d;
    @(posedge i_mclk);
    i_req <= 1'b0;
  endtask
  // Settings land two edges after the strobe, plus the host stage
  task automatic cmd(input logic [7:0] op, input int n, input logic [7:0] p0, input logic [7:0] p1);
    send(1'b0, 1'b0, op);
    if (n > 0) send(1'b1, 1'b0, p0);
    if (n > 1) send(1'b1, 1'b0, p1);
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] e, input logic [7:0] m, input logic want);
    int k;
    send(1'b1, 1'b1, 8'h00);
    k = 0;
    while (o_rvalid !== 1'b1 && k < 8) begin
      @(posedge i_mclk);
      k++;
    end
    if (!want) chk("extra read", 64'(k), 64'd8);
    else if (k == 8) begin
      chk("rvalid", 64'(o_rvalid), 64'd1);
      close_out();
    end
    else chk("status", 64'(o_rdata & m), 64'(e));
  endtask
  function automatic logic [15:0] obs(input int s);
    case (s)
      0: return 16'(o_oscillator_on);
      1: return 16'(o_power_on);
      2: return 16'(o_rate_doubler);
      3: return 16'(o_bias_ratio_code);
      4: return 16'(o_bias_denominator);
      5: return 16'(o_contrast_code);
      6: return 16'(o_discharge);
      7: return o_rate_codes;
      default: return o_slope_signs;
    endcase
  endfunction
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // ==========================================================
  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_req = 1'b0;
    i_req_param = 1'b0;
    i_req_read = 1'b0;
    i_req_data = 8'h00;
    i_band_sel = 4'h0;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].n, rows[i].p0, rows[i].p1);
      chk("row", 64'(obs(rows[i].sel)), 64'(rows[i].exp));
    end
    chk("order ok", 64'(o_order_error), 64'd0);
    for (int d = 0; d < 2; d++) begin
      cmd(OP_RATE_LEVEL, 1, 8'(d), 8'h00);
      for (int c = 0; c < 16; c++) begin
        cmd(OP_RATE_TABLE, 2, 8'(c), 8'h00);
        chk("fps", 64'(o_frame_rate), 64'(d ? FR2[c] : FR1[c]));
      end
    end
    send(1'b0, 1'b0, OP_SLOPE);
    for (int k = 0; k < 8; k++) send(1'b1, 1'b0, {4'(2 * k + 1), 4'(2 * k)});
    cmd(8'he3, 0, 8'h00, 8'h00);
    chk("slopes", o_slope_codes, 64'hfedcba9876543210);
    foreach (bands[j]) begin
      i_band_sel <= 4'(bands[j]);
      repeat (4) @(posedge i_mclk);
      chk("coeff", 64'(o_band_coeff_10mv), 64'(coef[j]));
    end
    send(1'b0, 1'b0, OP_CONTRAST);
    send(1'b1, 1'b0, 8'h10);
    cmd(OP_POWER_CTRL, 1, 8'h15, 8'h00);
    chk("abort", 64'(o_contrast_code), 64'h155);
    cmd(8'ha9, 0, 8'h00, 8'h00);
    chk("standby power", 64'({o_standby, o_power_on}), 64'h80);
    cmd(8'ha8, 0, 8'h00, 8'h00);
    cmd(OP_POWER_CTRL, 1, 8'h15, 8'h00);
    cmd(OP_DRIVE_METHOD, 1, 8'h19, 8'h00);
    cmd(OP_SCAN, 1, 8'hf3, 8'h00);
    cmd(8'h69, 0, 8'h00, 8'h00);
    cmd(8'haf, 0, 8'h00, 8'h00);
    cmd(OP_STATUS, 0, 8'h00, 8'h00);
    rd(8'hd5, 8'hff, 1'b1);
    rd(8'hec, 8'hff, 1'b1);
    rd(8'h00, 8'h00, 1'b0);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk("reset", 64'({o_contrast_code, o_bias_denominator, o_power_on}), 64'h300);
    send(1'b0, 1'b0, 8'he3);
    @(posedge i_mclk);
    chk("busy", 64'(o_busy), 64'd1);
    cmd(OP_POWER_CTRL, 1, 8'h01, 8'h00);
    chk("order error", 64'(o_order_error), 64'd1);
    close_out();
  end
endmodule // lcd_power_temp_cmd_decoder_test
